/* File: shared/dsq_consts.svh */
// Timing, width and reset constants for the buffered output sequencer.
`ifndef DSQ_CONSTS_SVH
`define DSQ_CONSTS_SVH

`define DSQ_CLK_HZ           100000000
`define DSQ_MAX_RATE_SPS     1000000
`define DSQ_DEF_RATE_SPS     320000
`define DSQ_MIN_PERIOD_CYC   ((`DSQ_CLK_HZ + `DSQ_MAX_RATE_SPS - 1) / `DSQ_MAX_RATE_SPS)
`define DSQ_DEF_PERIOD_CYC   ((`DSQ_CLK_HZ + `DSQ_DEF_RATE_SPS - 1) / `DSQ_DEF_RATE_SPS)
`define DSQ_DATA_W           16
`define DSQ_DIV_W            16
`define DSQ_DATA_RST         16'h0000

`endif

/* File: shared/dsq_pkg.sv */
// Types shared by the buffered output sequencer files.
package dsq_pkg;

	typedef struct packed {
		logic        eof;
		logic [15:0] data;
	} out_word_t;

	typedef struct packed {
		logic group_mode;
		logic int_clk_sel;
		logic out_clk_en;
		logic rate_gen_en;
	} ctl_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_LOAD   = 3'b010,
		ST_COMMIT = 3'b100
	} seq_state_t;

endpackage

/* File: core/out_fifo.sv */
// Output sample FIFO with registered read data and a flush.
`timescale 1ns/1ps
module out_fifo #(
	parameter int W     = 17,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input  logic                   clk_i,
	input  logic                   arst_n_i,
	input  logic                   flush_i,
	// Fill side.
	input  logic                   wr_valid_i,
	input  logic [W-1:0]           wr_data_i,
	output logic                   wr_ready_o,
	// Drain side; data appear in the cycle after the pop.
	output logic                   rd_valid_o,
	input  logic                   rd_ready_i,
	output logic [W-1:0]           rd_data_o,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] nxt_wp;
	logic [AW-1:0] rp_ff;
	logic [AW-1:0] nxt_rp;
	logic [AW:0]   cnt_ff;
	logic [AW:0]   nxt_cnt;
	logic [W-1:0]  rd_ff;
	logic [W-1:0]  nxt_rd;
	logic          push;
	logic          pop;

	// Ready drops during a flush, so a word offered then is held, not silently lost.
	assign wr_ready_o = (cnt_ff != (AW+1)'(DEPTH)) & ~flush_i;
	assign rd_valid_o = cnt_ff != '0;
	assign push       = wr_valid_i & wr_ready_o & ~flush_i;
	assign pop        = rd_valid_o & rd_ready_i & ~flush_i;
	assign rd_data_o  = rd_ff;
	assign level_o    = cnt_ff;

	// Pointers wrap naturally, so DEPTH must be a power of two.
	always_comb begin
		nxt_wp  = wp_ff;
		nxt_rp  = rp_ff;
		nxt_rd  = rd_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		if (push) begin
			nxt_wp = wp_ff + 1'b1;
		end
		if (pop) begin
			nxt_rp = rp_ff + 1'b1;
			nxt_rd = mem[rp_ff];
		end
		if (flush_i) begin
			nxt_wp  = '0;
			nxt_rp  = '0;
			nxt_cnt = '0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
			rd_ff  <= '0;
		end else begin
			wp_ff  <= nxt_wp;
			rp_ff  <= nxt_rp;
			cnt_ff <= nxt_cnt;
			rd_ff  <= nxt_rd;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_ff] <= wr_data_i;
		end
	end
endmodule

/* File: core/dac_output_buffer_sequencer.sv */
// Buffered analog output sequencer: FIFO, sample clock choice and channel update.
// Behaviour
// RULE1: Group mode holds values and drives all active channels once group complete.
// RULE2: Group mode: first channel's value waits in FIFO, outputs unchanged until complete.
// RULE3: Internal clock select high takes the update clock from the rate generator.
// RULE4: Updates need output clock gate and generator enable; generator starts at default rate. With the external clock, only the gate is needed.
// RULE5: Flush discards all stored values and leaves the FIFO empty.
// RULE6: Threshold flag low whenever fill level is below programmed threshold.
// RULE7: Host should set threshold to a quarter of its load block size.
// RULE8: Updates never exceed maximum rate; faster writes stay queued, never dropped.
// RULE9: FIFO accepts loading at full transfer rate without losing values.
// RULE10: Host must load faster than sample rate times active channel count.
// RULE11: Host waits for flag low, writes a whole block, and repeats.
// RULE12: Writing the rate generator value sets the internal sample clock frequency.
// RULE13: Without group mode each value updates its own channel on the next tick.
// RULE14: End-of-frame bit ignored; only the low sixteen data bits are used.
// RULE15: Internal clock select low takes the update clock from the external input.
// RULE16: Threshold flag returns high once level is at or above threshold.
// RULE17: Values leave in write order and fill active channels in ascending order.
`timescale 1ns/1ps
`include "dsq_consts.svh"
module dac_output_buffer_sequencer #(
	parameter int NUM_CH = 2,
	parameter int DEPTH  = 4
) (
	// Clock and reset.
	input  logic                                 clk_i,
	input  logic                                 arst_n_i,
	// Sample load stream.
	input  logic                                 wr_valid_i,
	input  dsq_pkg::out_word_t                   wr_data_i,
	output logic                                 wr_ready_o,
	// Control bits.
	input  dsq_pkg::ctl_t                        ctl_i,
	input  logic [NUM_CH-1:0]                    active_i,
	input  logic                                 flush_i,
	input  logic [$clog2(DEPTH):0]               thresh_i,
	input  logic                                 rate_wr_i,
	input  logic [`DSQ_DIV_W-1:0]                rate_div_i,
	input  logic                                 ext_clk_i,
	// Status.
	output logic                                 thresh_flag_o,
	output logic [$clog2(DEPTH):0]               level_o,
	// Channel outputs.
	output logic [NUM_CH-1:0][`DSQ_DATA_W-1:0]  dac_val_o,
	output logic [NUM_CH-1:0]                    dac_upd_o
);
	import dsq_pkg::*;

	localparam int CW       = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
	localparam int LOAD_MAX = 40;
	localparam logic [`DSQ_DIV_W-1:0] MIN_PER = `DSQ_DIV_W'(`DSQ_MIN_PERIOD_CYC);
	localparam logic [`DSQ_DIV_W-1:0] DEF_PER = `DSQ_DIV_W'(`DSQ_DEF_PERIOD_CYC);

	// ************************************************************
	// Channel helpers
	// ************************************************************
	function automatic logic [CW-1:0] next_active(input logic [NUM_CH-1:0] m,
						       input logic [CW-1:0] cur);
		logic [CW-1:0] res;
		int            idx;
		res = cur;
		for (int i = NUM_CH; i >= 1; i--) begin
			idx = (int'(cur) + i) % NUM_CH;
			if (m[idx]) begin
				res = CW'(idx);
			end
		end
		return res;
	endfunction

	function automatic logic [CW:0] count_active(input logic [NUM_CH-1:0] m);
		logic [CW:0] n;
		n = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			n = n + (CW+1)'(m[i]);
		end
		return n;
	endfunction

	// ************************************************************
	// Sample FIFO
	// ************************************************************
	logic      rd_valid;
	logic      rd_ready;
	out_word_t rd_data;

	// Depth covers a full group and a 100 MHz fill outpaces any loading rate.
	out_fifo #(.W($bits(out_word_t)), .DEPTH(DEPTH)) u_fifo (
		.clk_i      (clk_i),
		.arst_n_i   (arst_n_i),
		.flush_i    (flush_i), // RULE5
		.wr_valid_i (wr_valid_i),
		.wr_data_i  (wr_data_i),
		.wr_ready_o (wr_ready_o), // RULE9
		.rd_valid_o (rd_valid),
		.rd_ready_i (rd_ready),
		.rd_data_o  (rd_data),
		.level_o    (level_o)
	);

	// ************************************************************
	// Sample clock
	// ************************************************************
	logic [`DSQ_DIV_W-1:0] div_ff;
	logic [`DSQ_DIV_W-1:0] nxt_div;
	logic [`DSQ_DIV_W-1:0] gen_ff;
	logic [`DSQ_DIV_W-1:0] nxt_gen;
	logic [`DSQ_DIV_W-1:0] hold_ff;
	logic [`DSQ_DIV_W-1:0] nxt_hold;
	logic                  ext_q_ff;
	logic                  thr_ff;
	logic                  nxt_thr;
	logic                  gen_tick;
	logic                  raw_tick;
	logic                  sample_tick;

	always_comb begin
		nxt_div = div_ff;
		if (rate_wr_i) begin
			nxt_div = (rate_div_i < MIN_PER) ? MIN_PER : rate_div_i; // RULE12 RULE8
		end
		gen_tick = 1'b0;
		nxt_gen  = gen_ff - 1'b1;
		if (!ctl_i.rate_gen_en) begin
			nxt_gen = div_ff - 1'b1;
		end else if (gen_ff == '0) begin
			gen_tick = 1'b1;
			nxt_gen  = div_ff - 1'b1;
		end
		// The external clock is sampled as a level, so only its rising edge counts.
		raw_tick = ctl_i.out_clk_en & (ctl_i.int_clk_sel ? gen_tick // RULE3 RULE4
						: (ext_clk_i & ~ext_q_ff)); // RULE15
		sample_tick = raw_tick & (hold_ff == '0); // RULE8
		nxt_hold    = (hold_ff == '0) ? hold_ff : hold_ff - 1'b1;
		if (sample_tick) begin
			nxt_hold = MIN_PER - 1'b1;
		end
		nxt_thr = int'(level_o) >= int'(thresh_i); // RULE6 RULE16
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_ff   <= DEF_PER;
			gen_ff   <= DEF_PER;
			hold_ff  <= '0;
			ext_q_ff <= 1'b0;
			thr_ff   <= 1'b0;
		end else begin
			div_ff   <= nxt_div;
			gen_ff   <= nxt_gen;
			hold_ff  <= nxt_hold;
			ext_q_ff <= ext_clk_i;
			thr_ff   <= nxt_thr;
		end
	end

	assign thresh_flag_o = thr_ff;

	// ************************************************************
	// Group sequencer
	// ************************************************************
	seq_state_t        state_ff;
	seq_state_t        nxt_state;
	logic [CW:0]       left_ff;
	logic [CW:0]       nxt_left;
	logic [CW-1:0]     ch_ff;
	logic [CW-1:0]     nxt_ch;
	logic [CW-1:0]     last_ff;
	logic [CW-1:0]     nxt_last;
	logic [CW-1:0]     cap_ch_ff;
	logic [CW-1:0]     nxt_cap_ch;
	logic              cap_ff;
	logic              nxt_cap;
	logic              grp_ff;
	logic              nxt_grp;
	logic [NUM_CH-1:0] mask_ff;
	logic [NUM_CH-1:0] nxt_mask;
	logic [NUM_CH-1:0] loaded_ff;
	logic [NUM_CH-1:0] nxt_loaded;
	logic [CW:0]       grp_n;
	logic              start;
	logic              pop;

	// A group starts only when all of its values already sit in the FIFO.
	assign grp_n = (active_i == '0) ? '0
		: (ctl_i.group_mode ? count_active(active_i) : (CW+1)'(1)); // RULE1 RULE13
	assign start = sample_tick & (state_ff == ST_IDLE) & (grp_n != '0)
		& (int'(level_o) >= int'(grp_n)); // RULE2 RULE8
	assign rd_ready = (state_ff == ST_LOAD) & (left_ff != '0);
	assign pop      = rd_ready & rd_valid & ~flush_i;

	always_comb begin
		nxt_state  = state_ff;
		nxt_left   = left_ff;
		nxt_ch     = ch_ff;
		nxt_last   = last_ff;
		nxt_cap    = 1'b0;
		nxt_cap_ch = cap_ch_ff;
		nxt_grp    = grp_ff;
		nxt_mask   = mask_ff;
		nxt_loaded = loaded_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start) begin
					nxt_state  = ST_LOAD;
					nxt_left   = grp_n;
					nxt_grp    = ctl_i.group_mode;
					nxt_mask   = active_i;
					nxt_loaded = '0;
					nxt_ch     = next_active(active_i, ctl_i.group_mode
							? CW'(NUM_CH - 1) : last_ff); // RULE17
				end
			end
			ST_LOAD: begin
				if (pop) begin
					nxt_left   = left_ff - 1'b1;
					nxt_cap    = 1'b1;
					nxt_cap_ch = ch_ff;
					nxt_last   = ch_ff;
					nxt_ch     = next_active(mask_ff, ch_ff); // RULE17
				end
				if (cap_ff) begin
					nxt_loaded[cap_ch_ff] = 1'b1;
				end
				if (left_ff == '0 && cap_ff) begin
					nxt_state = ST_COMMIT;
				end
			end
			ST_COMMIT: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (flush_i) begin
			nxt_state = ST_IDLE; // RULE5
			nxt_cap   = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff  <= ST_IDLE;
			left_ff   <= '0;
			ch_ff     <= '0;
			last_ff   <= CW'(NUM_CH - 1);
			cap_ff    <= 1'b0;
			cap_ch_ff <= '0;
			grp_ff    <= 1'b0;
			mask_ff   <= '0;
			loaded_ff <= '0;
		end else begin
			state_ff  <= nxt_state;
			left_ff   <= nxt_left;
			ch_ff     <= nxt_ch;
			last_ff   <= nxt_last;
			cap_ff    <= nxt_cap;
			cap_ch_ff <= nxt_cap_ch;
			grp_ff    <= nxt_grp;
			mask_ff   <= nxt_mask;
			loaded_ff <= nxt_loaded;
		end
	end

	// ************************************************************
	// Channel registers
	// ************************************************************
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		logic [`DSQ_DATA_W-1:0] shadow_ff;
		logic [`DSQ_DATA_W-1:0] nxt_shadow;
		logic [`DSQ_DATA_W-1:0] val_ff;
		logic [`DSQ_DATA_W-1:0] nxt_val;
		logic                   upd_ff;
		logic                   nxt_upd;

		always_comb begin
			nxt_shadow = shadow_ff;
			if (cap_ff && cap_ch_ff == CW'(c)) begin
				nxt_shadow = rd_data.data; // RULE14
			end
			nxt_val = val_ff;
			nxt_upd = 1'b0;
			if (state_ff == ST_COMMIT && loaded_ff[c]) begin
				nxt_val = shadow_ff; // RULE1 RULE13
				nxt_upd = 1'b1;
			end
		end

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				shadow_ff <= `DSQ_DATA_RST;
				val_ff    <= `DSQ_DATA_RST;
				upd_ff    <= 1'b0;
			end else begin
				shadow_ff <= nxt_shadow;
				val_ff    <= nxt_val;
				upd_ff    <= nxt_upd;
			end
		end

		assign dac_val_o[c] = val_ff;
		assign dac_upd_o[c] = upd_ff;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	logic [`DSQ_DIV_W-1:0] gap_ff;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gap_ff <= '1;
		end else if (sample_tick) begin
			gap_ff <= '0;
		end else if (gap_ff != '1) begin
			gap_ff <= gap_ff + 1'b1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence start_s;
		state_ff == ST_IDLE && start;
	endsequence

	sequence commit_s;
		state_ff == ST_COMMIT;
	endsequence

	// A flush aborts a load in flight, so it also ends this check.
	group_done_a: assert property (disable iff (!arst_n_i || flush_i) // RULE1
		start_s |-> ##[1:LOAD_MAX] commit_s ##1 (dac_upd_o != '0))
		else $error("Started group never reached the outputs.");
	group_all_a: assert property (commit_s and grp_ff |=> dac_upd_o == $past(mask_ff)) // RULE1
		else $error("Group update did not drive every active channel.");
	group_hold_a: assert property (state_ff == ST_LOAD |-> dac_upd_o == '0) // RULE2
		else $error("Output changed before the group was complete.");
	group_wait_a: assert property (state_ff == ST_LOAD && left_ff != '0 |-> rd_valid) // RULE2
		else $error("Group started without all values stored.");
	int_clock_a: assert property (ctl_i.int_clk_sel && ctl_i.out_clk_en && gen_tick
		&& hold_ff == '0 |-> sample_tick) // RULE3
		else $error("Internal generator tick was not used.");
	ext_clock_a: assert property (!ctl_i.int_clk_sel && ctl_i.out_clk_en && ext_clk_i
		&& !$past(ext_clk_i) && hold_ff == '0 |-> sample_tick) // RULE15
		else $error("External clock edge was not used.");
	clock_gate_a: assert property (sample_tick |-> ctl_i.out_clk_en
		&& (!ctl_i.int_clk_sel || ctl_i.rate_gen_en)) // RULE4
		else $error("Sample tick without clock enables.");
	flush_empty_a: assert property (flush_i |=> level_o == '0 && state_ff == ST_IDLE) // RULE5
		else $error("Flush left values stored.");
	thresh_flag_a: assert property (##1 thresh_flag_o == ($past(int'(level_o))
		>= $past(int'(thresh_i)))) // RULE6
		else $error("Threshold flag does not follow the fill level.");
	rate_limit_a: assert property (sample_tick |-> gap_ff >= MIN_PER - 1'b1) // RULE8
		else $error("Sample ticks closer than the maximum rate allows.");
	seq_single_a: assert property (commit_s and !grp_ff |=> $onehot(dac_upd_o)) // RULE13
		else $error("Sequential mode updated more than one channel.");
	load_accept_a: assert property (int'(level_o) < DEPTH && !flush_i |-> wr_ready_o) // RULE9
		else $error("FIFO refused a value while not full.");
endmodule

/* File: dv/host_loader.sv */
// Host side model that streams queued output words into the sequencer.
`timescale 1ns/1ps
module host_loader
	import dsq_pkg::*;
(
	// Clock and reset.
	input  wire logic      clk_i,
	input  wire logic      arst_n_i,
	// Load stream.
	input  wire logic      wr_ready_i,
	output logic           wr_valid_o,
	output dsq_pkg::out_word_t wr_data_o
);
	out_word_t q[$];
	logic      taken;

	task automatic push(input out_word_t w);
		q.push_back(w);
	endtask

	// ****************************************
	// Offer words back to back; hold each until it is taken.
	// ****************************************
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_valid_o <= 1'b0;
			wr_data_o  <= '0;
		end else begin
			taken = wr_valid_o && wr_ready_i;
			if (taken) begin
				void'(q.pop_front());
			end
			if (wr_valid_o && !taken) begin
				wr_valid_o <= 1'b1;
			end else if (q.size() == 0) begin
				// Idle data toggles so a stale word can never pass for a fresh one.
				wr_valid_o <= 1'b0;
				wr_data_o  <= ~wr_data_o;
			end else begin
				wr_valid_o <= 1'b1;
				wr_data_o  <= q[0];
			end
		end
	end
endmodule

/* File: dv/dac_output_buffer_sequencer_test.sv */
// Self-checking bench for the buffered output sequencer.
`timescale 1ns/1ps
module dac_output_buffer_sequencer_test;
	import dsq_pkg::*;
	logic            clk_i, arst_n_i, wr_valid, wr_ready, flush_i, rate_wr_i, ext_clk_i, flag;
	out_word_t       wr_data;
	ctl_t            ctl_i;
	logic [1:0]      active_i, dac_upd, seen_upd;
	logic [2:0]      thresh_i, level;
	logic [15:0]     rate_div_i;
	logic [1:0][15:0] dac_val;
	int              n_errors, tests_run, cycles, n;

	dac_output_buffer_sequencer #(.NUM_CH(2), .DEPTH(4)) uut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .wr_valid_i(wr_valid), .wr_data_i(wr_data),
		.wr_ready_o(wr_ready), .ctl_i(ctl_i), .active_i(active_i), .flush_i(flush_i),
		.thresh_i(thresh_i), .rate_wr_i(rate_wr_i), .rate_div_i(rate_div_i),
		.ext_clk_i(ext_clk_i), .thresh_flag_o(flag), .level_o(level),
		.dac_val_o(dac_val), .dac_upd_o(dac_upd));

	host_loader loader (.clk_i(clk_i), .arst_n_i(arst_n_i), .wr_ready_i(wr_ready),
		.wr_valid_o(wr_valid), .wr_data_o(wr_data));

	// ****************************************
	// Common tasks.
	// ****************************************
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic settle(input int c);
		seen_upd = 2'h0;
		repeat (c) begin
			@(negedge clk_i);
			seen_upd = seen_upd | dac_upd;
		end
	endtask

	task automatic wait_upd(output int c);
		c = 0;
		do begin
			@(negedge clk_i);
			c++;
		end while (dac_upd === 2'h0 && c < 1000);
		check(c < 1000, 1);
	endtask

	task automatic pulse_ext();
		@(posedge clk_i) ext_clk_i <= 1'b1;
		@(posedge clk_i) ext_clk_i <= 1'b0;
	endtask

	task automatic pulse_flush();
		@(posedge clk_i) flush_i <= 1'b1;
		@(posedge clk_i) flush_i <= 1'b0;
	endtask

	task automatic set_rate(input logic [15:0] d);
		@(posedge clk_i) ctl_i <= 4'hE;
		rate_div_i <= d;
		rate_wr_i  <= 1'b1;
		@(posedge clk_i) rate_wr_i <= 1'b0;
		ctl_i <= 4'hF;
	endtask

	// ****************************************
	// Scenarios.
	// ****************************************
	task automatic t_fill();
		for (int i = 1; i <= 4; i++) begin
			loader.push({1'b0, 16'h1000 + 16'(i)});
			settle(4);
			check(level, i);
			check(flag, i >= 2);
		end
		loader.push({1'b0, 16'h1005});
		settle(4);
		check({wr_ready, level}, 4'h4);
		pulse_flush();
		settle(1);
		check(level, 0);
		settle(4);
		check({level, flag}, 4'h2);
		pulse_flush();
		settle(3);
	endtask

	task automatic t_seq_ext();
		@(posedge clk_i) ctl_i <= 4'h2;
		loader.push({1'b1, 16'hA000});
		loader.push({1'b1, 16'hA001});
		settle(4);
		pulse_ext();
		wait_upd(n);
		check({dac_upd, dac_val[0]}, 18'h1A000);
		settle(2);
		check(level, 1);
		settle(150);
		pulse_ext();
		wait_upd(n);
		check({dac_upd, dac_val[1], dac_val[0]}, 34'h2A001A000);
		@(posedge clk_i) ctl_i <= 4'h5;
		loader.push({1'b0, 16'hA002});
		settle(700);
		check({seen_upd, level}, 5'h01);
		pulse_flush();
		settle(3);
	endtask

	task automatic t_one_ch();
		@(posedge clk_i) ctl_i <= 4'h2;
		active_i <= 2'h2;
		loader.push({1'b0, 16'hE000});
		settle(4);
		pulse_ext();
		wait_upd(n);
		check({dac_upd, dac_val[1]}, 18'h2E000);
		@(posedge clk_i) active_i <= 2'h3;
	endtask

	task automatic t_group();
		@(posedge clk_i) ctl_i <= 4'hF;
		loader.push({1'b1, 16'hB000});
		settle(800);
		check({seen_upd, level}, 5'h01);
		loader.push({1'b1, 16'hB001});
		wait_upd(n);
		check({dac_upd, dac_val[1], dac_val[0]}, 34'h3B001B000);
		check(n <= 320, 1);
		settle(3);
		check(level, 0);
	endtask

	task automatic t_rate();
		int w;
		@(posedge clk_i) thresh_i <= 3'h1;
		set_rate(16'd200);
		for (int b = 0; b < 2; b++) begin
			w = 0;
			while (flag !== 1'b0 && w < 1000) begin
				@(negedge clk_i);
				w++;
			end
			check(w < 1000, 1);
			for (int i = 0; i < 4; i++) begin
				loader.push({1'b0, 16'hC000 + 16'(4 * b + i)});
			end
			settle(6);
			check(flag, 1);
			wait_upd(n);
			// The gap is counted from the previous update, flag wait and settle included.
			if (b > 0) begin
				check(w + 6 + n, 200);
			end
			wait_upd(n);
			check(n, 200);
			check(dac_val[0], 16'hC000 + 16'(4 * b + 2));
		end
		set_rate(16'd50);
		for (int i = 0; i < 4; i++) begin
			loader.push({1'b0, 16'hD000 + 16'(i)});
		end
		wait_upd(n);
		wait_upd(n);
		check(n, 100);
		settle(3);
		check(level, 0);
	endtask

	// ****************************************
	// Clock, reset, run and watchdog.
	// ****************************************
	initial clk_i = 1'b0;
	always #5 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	initial begin
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		arst_n_i = 1'b0;
		flush_i = 1'b0;
		rate_wr_i = 1'b0;
		ext_clk_i = 1'b0;
		ctl_i = 4'h0;
		active_i = 2'h3;
		thresh_i = 3'h2;
		rate_div_i = 16'h0000;
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		settle(2);
		check({wr_ready, level, flag, dac_upd, dac_val}, 39'h4000000000);
		t_fill();
		t_seq_ext();
		t_one_ch();
		t_group();
		t_rate();
		tally_and_finish();
	end
endmodule
